/* File: rtl/flash_spc_pkg.sv */
package flash_spc_pkg;
	localparam logic [7:0]  CTRL_OFF      = 8'h00;
	localparam logic [7:0]  ADRL_OFF      = 8'h04;
	localparam logic [7:0]  ADRU_OFF      = 8'h08;
	localparam logic [7:0]  KEY_OFF       = 8'h0c;
	localparam logic [7:0]  PAGE_OFF      = 8'h10;
	localparam int          START_BIT     = 15;
	localparam int          WRITE_ENABLE_BIT_BIT      = 14;
	localparam int          ERR_BIT       = 13;
	localparam logic [6:0]  OP_ROW_ERASE  = 7'h41;
	localparam logic [6:0]  OP_BLK_PROG   = 7'h01;
	localparam logic [7:0]  KEY_FIRST     = 8'h55;
	localparam logic [7:0]  KEY_SECOND    = 8'haa;
	localparam logic [15:0] CTRL_RST      = 16'h0000;
	localparam logic [15:0] ADR_RST       = 16'h0000;
	localparam logic [7:0]  PAGE_RST      = 8'h00;
	localparam int          ROW_WORDS     = 32;
	localparam int          BLK_WORDS     = 4;
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          OP_TIME_NS    = 2000000;
	localparam int          OP_CYCLES_DFLT = (OP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0]  RESP_OKAY     = 2'b00;
	localparam logic [1:0]  RESP_SLVERR   = 2'b10;

	typedef enum logic [1:0] {KEY_NONE, KEY_GOT_FIRST, KEY_ARMED} key_state_t;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        high;
		logic        byte_mode;
		logic [15:0] ea;
		logic [15:0] wdata;
	} tbl_req_t;

	typedef struct packed {
		logic        valid;
		logic        erase;
		logic [23:0] addr;
		logic [95:0] data;
	} flash_op_t;
endpackage : flash_spc_pkg

/* File: rtl/flash_self_program_controller.sv */
// Register access over AXI4-Lite and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module flash_self_program_controller import flash_spc_pkg::*; #(
	parameter int OP_CYCLES = OP_CYCLES_DFLT
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Register bus
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Table instruction port from the core
	input  wire tbl_req_t    tbl_req,
	output logic             tbl_done,
	output logic [15:0]      tbl_rdata,
	// Flash array
	output logic [23:0]      flash_rd_addr,
	input  wire logic [23:0] flash_rd_data,
	output flash_op_t        flash_op,
	output logic             cpu_stall
);
	function automatic logic [15:0] rd_sel(input logic [23:0] w, input logic hi,
			input logic bm, input logic odd);
		if (hi) begin
			rd_sel = (bm && odd) ? 16'h0000 : {8'h00, w[23:16]};
		end else if (bm) begin
			rd_sel = {8'h00, odd ? w[15:8] : w[7:0]};
		end else begin
			rd_sel = w[15:0];
		end
	endfunction : rd_sel

	function automatic logic [23:0] wr_merge(input logic [23:0] w, input logic hi,
			input logic bm, input logic odd, input logic [15:0] d);
		wr_merge = w;
		if (hi) begin
			if (!(bm && odd)) begin
				wr_merge[23:16] = d[7:0];
			end
		end else if (!bm) begin
			wr_merge[15:0] = d;
		end else if (odd) begin
			wr_merge[15:8] = d[7:0];
		end else begin
			wr_merge[7:0] = d[7:0];
		end
	endfunction : wr_merge

	// Bus state
	logic        awready_q, awready_d, wready_q, wready_d;
	logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [7:0]  waddr_q, waddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0]  wstrb_q, wstrb_d;
	logic        bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
	logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;
	logic        wr_fire;
	// Core state
	logic [15:0] ctrl_q, ctrl_d, adrl_q, adrl_d, adru_q, adru_d;
	logic [7:0]  page_q, page_d;
	key_state_t  key_q, key_d;
	logic [19:0] timer_q, timer_d;
	logic        stall_q, stall_d;
	flash_op_t   op_q, op_d;
	logic [23:0] latch_q [ROW_WORDS];
	logic [23:0] latch_d [ROW_WORDS];
	tbl_req_t    hold_q, hold_d;
	logic        phase_q, phase_d, done_q, done_d;
	logic [15:0] trd_q, trd_d;
	logic [23:0] rda_q, rda_d;
	logic        take, launch;
	logic [2:0]  blk;

	assign s_axi_awready = awready_q;
	assign s_axi_wready  = wready_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign tbl_done      = done_q;
	assign tbl_rdata     = trd_q;
	assign flash_rd_addr = rda_q;
	assign flash_op      = op_q;
	assign cpu_stall     = stall_q;

	// Write address and data taken in either order
	always_comb begin
		aw_got_d = aw_got_q;
		w_got_d  = w_got_q;
		waddr_d  = waddr_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		bvalid_d = bvalid_q && !s_axi_bready;
		bresp_d  = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rresp_d  = rresp_q;
		rdata_d  = rdata_q;
		if (s_axi_awvalid && awready_q) begin
			aw_got_d = 1'b1;
			waddr_d  = s_axi_awaddr;
		end
		if (s_axi_wvalid && wready_q) begin
			w_got_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		wr_fire = aw_got_q && w_got_q && !bvalid_q;
		if (wr_fire) begin
			aw_got_d = 1'b0;
			w_got_d  = 1'b0;
			bvalid_d = 1'b1;
			bresp_d  = (waddr_q[7:2] <= PAGE_OFF[7:2] && waddr_q[1:0] == 2'b00)
				? RESP_OKAY : RESP_SLVERR;
		end
		awready_d = !aw_got_d && !bvalid_d;
		wready_d  = !w_got_d && !bvalid_d;
		if (rvalid_q && s_axi_rready) begin
			rvalid_d  = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid && arready_q) begin
			arready_d = 1'b0;
			rvalid_d  = 1'b1;
			rresp_d   = RESP_OKAY;
			case (s_axi_araddr)
				CTRL_OFF: rdata_d = {16'h0000, ctrl_q};
				ADRL_OFF: rdata_d = {16'h0000, adrl_q};
				ADRU_OFF: rdata_d = {16'h0000, adru_q};
				KEY_OFF:  rdata_d = 32'h0000_0000;
				PAGE_OFF: rdata_d = {24'h000000, page_q};
				default: begin
					rdata_d = 32'h0000_0000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q  <= 1'b0;
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			waddr_q   <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bvalid_q  <= 1'b0;
			bresp_q   <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
			rresp_q   <= RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
		end else begin
			awready_q <= awready_d;
			wready_q  <= wready_d;
			aw_got_q  <= aw_got_d;
			w_got_q   <= w_got_d;
			waddr_q   <= waddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			arready_q <= arready_d;
			rvalid_q  <= rvalid_d;
			rresp_q   <= rresp_d;
			rdata_q   <= rdata_d;
		end
	end

	// Registers, unlock, operation timer and table port
	always_comb begin
		logic [15:0] cw;
		cw      = ctrl_q;
		ctrl_d  = ctrl_q;
		adrl_d  = adrl_q;
		adru_d  = adru_q;
		page_d  = page_q;
		key_d   = key_q;
		timer_d = timer_q;
		stall_d = stall_q;
		op_d    = op_q;
		op_d.valid = 1'b0;
		latch_d = latch_q;
		hold_d  = hold_q;
		phase_d = 1'b0;
		done_d  = 1'b0;
		trd_d   = trd_q;
		rda_d   = rda_q;
		launch  = 1'b0;
		blk     = adrl_q[5:3];
		if (wstrb_q[0]) begin
			cw[7:0] = wdata_q[7:0];
		end
		if (wstrb_q[1]) begin
			cw[15:8] = wdata_q[15:8];
		end
		if (wr_fire) begin
			key_d = KEY_NONE;
			if (waddr_q == KEY_OFF && wstrb_q[0] && wdata_q[7:0] == KEY_FIRST) begin
				key_d = KEY_GOT_FIRST;
			end else if (waddr_q == KEY_OFF && wstrb_q[0] && key_q == KEY_GOT_FIRST
					&& wdata_q[7:0] == KEY_SECOND) begin
				key_d = KEY_ARMED;
			end
		end
		if (wr_fire && !ctrl_q[START_BIT]) begin
			case (waddr_q)
				CTRL_OFF: begin
					ctrl_d = {1'b0, cw[WRITE_ENABLE_BIT_BIT], cw[ERR_BIT] & ctrl_q[ERR_BIT], cw[12:0]};
					if (cw[START_BIT] && cw[WRITE_ENABLE_BIT_BIT] && key_q == KEY_ARMED) begin
						if (cw[6:0] == OP_ROW_ERASE || cw[6:0] == OP_BLK_PROG) begin
							launch = 1'b1;
						end else begin
							ctrl_d[ERR_BIT] = 1'b1;
						end
					end
				end
				ADRL_OFF: adrl_d = cw;
				ADRU_OFF: adru_d = {8'h00, cw[7:0]};
				PAGE_OFF: page_d = cw[7:0];
				default: ;
			endcase
		end
		if (launch) begin
			ctrl_d[START_BIT] = 1'b1;
			timer_d = 20'(OP_CYCLES - 1);
			stall_d = 1'b1;
			op_d.valid = 1'b1;
			op_d.erase = (cw[6:0] == OP_ROW_ERASE);
			if (cw[6:0] == OP_ROW_ERASE) begin
				op_d.addr = {adru_q[7:0], adrl_q[15:6], 6'h00};
			end else begin
				op_d.addr = {adru_q[7:0], adrl_q[15:3], 3'h0};
			end
			for (int i = 0; i < BLK_WORDS; i++) begin
				op_d.data[i*24 +: 24] = latch_q[{blk[1:0], i[1:0]} + 5'(blk[2]) * 5'd16];
			end
		end else if (ctrl_q[START_BIT]) begin
			if (timer_q == 20'h00000) begin
				ctrl_d[START_BIT] = 1'b0;
				stall_d = 1'b0;
			end else begin
				timer_d = timer_q - 20'h00001;
			end
		end
		take = tbl_req.valid && !phase_q && !done_q && !ctrl_q[START_BIT];
		if (take) begin
			phase_d = 1'b1;
			hold_d  = tbl_req;
			rda_d   = {page_q, tbl_req.ea};
			adrl_d  = tbl_req.ea;
			adru_d  = {8'h00, page_q};
		end
		if (phase_q) begin
			done_d = 1'b1;
			if (hold_q.write) begin
				latch_d[hold_q.ea[5:1]] = wr_merge(latch_q[hold_q.ea[5:1]], hold_q.high,
					hold_q.byte_mode, hold_q.ea[0], hold_q.wdata);
			end else begin
				trd_d = rd_sel(flash_rd_data, hold_q.high, hold_q.byte_mode, hold_q.ea[0]);
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q  <= CTRL_RST;
			adrl_q  <= ADR_RST;
			adru_q  <= ADR_RST;
			page_q  <= PAGE_RST;
			key_q   <= KEY_NONE;
			timer_q <= 20'h00000;
			stall_q <= 1'b0;
			op_q    <= '0;
			hold_q  <= '0;
			phase_q <= 1'b0;
			done_q  <= 1'b0;
			trd_q   <= 16'h0000;
			rda_q   <= 24'h000000;
			for (int i = 0; i < ROW_WORDS; i++) begin
				latch_q[i] <= 24'h000000;
			end
		end else begin
			ctrl_q  <= ctrl_d;
			adrl_q  <= adrl_d;
			adru_q  <= adru_d;
			page_q  <= page_d;
			key_q   <= key_d;
			timer_q <= timer_d;
			stall_q <= stall_d;
			op_q    <= op_d;
			hold_q  <= hold_d;
			phase_q <= phase_d;
			done_q  <= done_d;
			trd_q   <= trd_d;
			rda_q   <= rda_d;
			latch_q <= latch_d;
		end
	end

	start_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(ctrl_q[START_BIT]) |-> $past(timer_q) == 20'h00000)
		else $error("start bit cleared before timer expiry");
	no_sw_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
		ctrl_q[START_BIT] && timer_q != 20'h00000 |=> ctrl_q[START_BIT])
		else $error("start bit dropped early");
	stall_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ctrl_q[START_BIT]) |-> cpu_stall && timer_q == 20'(OP_CYCLES - 1))
		else $error("stall or timer wrong at launch");
	key_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ctrl_q[START_BIT]) |-> $past(key_q) == KEY_ARMED && ctrl_q[WRITE_ENABLE_BIT_BIT])
		else $error("start without unlock");
	key_rearm_a: assert property (@(posedge aclk) disable iff (!aresetn)
		$rose(ctrl_q[START_BIT]) |-> key_q == KEY_NONE)
		else $error("unlock survived launch");
	tbl_timing_a: assert property (@(posedge aclk) disable iff (!aresetn)
		take |=> !tbl_done ##1 tbl_done ##1 !tbl_done)
		else $error("table access not two cycles");
	addr_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
		take |=> adrl_q == $past(tbl_req.ea) && adru_q[7:0] == $past(page_q))
		else $error("address not captured");
	op_align_a: assert property (@(posedge aclk) disable iff (!aresetn)
		flash_op.valid |-> (flash_op.erase ? flash_op.addr[5:0] == 6'h00
			: flash_op.addr[2:0] == 3'h0) ##1 !flash_op.valid)
		else $error("operation address misaligned");
endmodule : flash_self_program_controller

/* File: testbench/table_core_model.sv */
`timescale 1ns/1ps
module table_core_model import flash_spc_pkg::*; (
	// Clock
	input  wire logic        aclk,
	// Table port
	output tbl_req_t         tbl_req,
	input  wire logic        tbl_done,
	input  wire logic [15:0] tbl_rdata
);
	initial tbl_req = '0;

	task automatic access(input logic w, input logic h, input logic b, input logic [15:0] ea,
		input logic [15:0] wd, output logic [15:0] rd, output int n);
		n = 0;
		tbl_req <= '{valid: 1'b1, write: w, high: h, byte_mode: b, ea: ea, wdata: wd};
		do begin
			@(posedge aclk);
			n++;
		end while (tbl_done !== 1'b1 && n < 50);
		rd = tbl_rdata;
		tbl_req <= '{valid: 1'b0, write: ~w, high: ~h, byte_mode: 1'b1, ea: ~ea, wdata: ~wd};
		@(posedge aclk);
	endtask : access
endmodule : table_core_model

/* File: testbench/test_flash_self_program_controller.sv */
`timescale 1ns/1ps
module test_flash_self_program_controller import flash_spc_pkg::*; ;
	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
	} row_t;

	localparam int OP = 40;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = '0;
	logic [7:0]  araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0]  wstrb = '0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, tbl_done, cpu_stall;
	logic [1:0]  bresp, rresp, r;
	logic [31:0] rdata, d;
	logic [15:0] tbl_rdata, r16;
	logic [23:0] flash_rd_addr, flash_rd_data;
	tbl_req_t    tbl_req;
	flash_op_t   flash_op, op_q;
	int          miscompares = 0, comparisons = 0, cyc = 0, op_count = 0, stall_cnt = 0;
	int          n, s0, c0;
	row_t        rows[5] = '{'{ADRL_OFF, 32'ha5c3, 32'ha5c3, RESP_OKAY},
		'{ADRU_OFF, 32'hffff_ff5a, 32'h5a, RESP_OKAY}, '{PAGE_OFF, 32'h1ab, 32'hab, RESP_OKAY},
		'{KEY_OFF, 32'h55, 32'h0, RESP_OKAY}, '{8'h20, 32'h1, 32'h0, RESP_SLVERR}};
	logic [39:0] bad[11] = '{{KEY_OFF, 32'haa}, {KEY_OFF, 32'h55}, {CTRL_OFF, 32'hc041},
		{KEY_OFF, 32'h55}, {ADRL_OFF, 32'h6047}, {KEY_OFF, 32'haa}, {CTRL_OFF, 32'hc041},
		{CTRL_OFF, 32'h0041}, {KEY_OFF, 32'h55}, {KEY_OFF, 32'haa}, {CTRL_OFF, 32'h8041}};

	always #2 aclk = ~aclk;
	// Array model: page byte on top, inverted word below
	assign flash_rd_data = {flash_rd_addr[23:16], ~flash_rd_addr[15:0]};

	flash_self_program_controller #(.OP_CYCLES(OP)) flash_self_program_controller_i (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tbl_req(tbl_req), .tbl_done(tbl_done),
		.tbl_rdata(tbl_rdata), .flash_rd_addr(flash_rd_addr),
		.flash_rd_data(flash_rd_data), .flash_op(flash_op), .cpu_stall(cpu_stall));

	table_core_model table_core_model_i (.aclk(aclk), .tbl_req(tbl_req),
		.tbl_done(tbl_done), .tbl_rdata(tbl_rdata));

	task automatic summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : summarize

	// Operation capture and hang guard
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (flash_op.valid === 1'b1) begin
			op_q <= flash_op;
			op_count <= op_count + 1;
		end
		if (cpu_stall === 1'b1)
			stall_cnt <= stall_cnt + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			summarize();
		end
	end

	task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
		comparisons++;
		if (e !== g) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		comparisons++;
		if (e !== g) begin
			miscompares++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_resp

	task automatic axw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		bit aw;
		bit w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= v;
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (!aw && awready === 1'b1) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready === 1'b1) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		rs = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask : axw

	task automatic axr(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : axr

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		axw(a, v, r);
		chk_resp("bresp", RESP_OKAY, r);
	endtask : wr

	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
		axr(a, d, r);
		chk_resp("rresp", RESP_OKAY, r);
		chk(nm, e, d);
	endtask : rdc

	task automatic tacc(input logic w, input logic h, input logic b, input logic [15:0] ea,
		input logic [15:0] v, input logic [15:0] e);
		table_core_model_i.access(w, h, b, ea, v, r16, n);
		chk("tbl cycles", 3, n);
		if (!w)
			chk("tbl rdata", e, r16);
	endtask : tacc

	task automatic wait_op();
		while (cpu_stall === 1'b1) @(posedge aclk);
		@(posedge aclk);
	endtask : wait_op

	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		rdc("ctrl rst", CTRL_OFF, 32'(CTRL_RST));
		rdc("adrl rst", ADRL_OFF, 32'(ADR_RST));
		foreach (rows[i]) begin
			axw(rows[i].a, rows[i].d, r);
			chk_resp("wr resp", rows[i].r, r);
			axr(rows[i].a, d, r);
			chk_resp("rd resp", rows[i].r, r);
			chk("readback", rows[i].e, d);
		end
		$display("test registers finished");
		wr(PAGE_OFF, 32'h12);
		tacc(1'b0, 1'b0, 1'b0, 16'h6008, 16'h0, 16'h9ff7);
		tacc(1'b0, 1'b1, 1'b0, 16'h6008, 16'h0, 16'h0012);
		tacc(1'b0, 1'b0, 1'b1, 16'h6009, 16'h0, 16'h009f);
		tacc(1'b0, 1'b1, 1'b1, 16'h6009, 16'h0, 16'h0000);
		for (int i = 0; i < 4; i++) begin
			tacc(1'b1, 1'b0, 1'b0, 16'h6000 + 16'(2 * i), 16'h1000 + 16'(i), 16'h0);
			tacc(1'b1, 1'b1, 1'b0, 16'h6000 + 16'(2 * i), 16'hff20 + 16'(i), 16'h0);
		end
		chk("rd addr", 24'h126006, flash_rd_addr);
		rdc("adrl cap", ADRL_OFF, 32'h6006);
		rdc("adru cap", ADRU_OFF, 32'h12);
		wr(CTRL_OFF, 32'h4001);
		wr(KEY_OFF, 32'(KEY_FIRST));
		wr(KEY_OFF, 32'(KEY_SECOND));
		s0 = stall_cnt;
		c0 = op_count;
		wr(CTRL_OFF, 32'hc001);
		repeat (2) @(posedge aclk);
		rdc("busy", CTRL_OFF, 32'hc001);
		wr(CTRL_OFF, 32'h4001);
		rdc("no clear", CTRL_OFF, 32'hc001);
		wait_op();
		chk("stall", OP, stall_cnt - s0);
		chk("op count", c0 + 1, op_count);
		chk("op kind", 0, op_q.erase);
		chk("op addr", 24'h126000, op_q.addr);
		chk("op data", {24'h231003, 24'h221002, 24'h211001, 24'h201000}, op_q.data);
		rdc("ctrl end", CTRL_OFF, 32'h4001);
		$display("test program finished");
		wr(ADRL_OFF, 32'h6047);
		wr(CTRL_OFF, 32'h4041);
		wr(KEY_OFF, 32'(KEY_FIRST));
		wr(KEY_OFF, 32'(KEY_SECOND));
		c0 = op_count;
		wr(CTRL_OFF, 32'hc041);
		wait_op();
		chk("erase kind", 1, op_q.erase);
		chk("erase addr", 24'h126040, op_q.addr);
		rdc("adrl kept", ADRL_OFF, 32'h6047);
		wr(CTRL_OFF, 32'hc041);
		foreach (bad[i])
			wr(bad[i][39:32], bad[i][31:0]);
		wr(KEY_OFF, 32'(KEY_FIRST));
		wr(KEY_OFF, 32'(KEY_SECOND));
		wr(CTRL_OFF, 32'hc005);
		rdc("err set", CTRL_OFF, 32'h6005);
		wr(CTRL_OFF, 32'h0005);
		rdc("err clear", CTRL_OFF, 32'h0005);
		repeat (4) @(posedge aclk);
		chk("locked", c0 + 1, op_count);
		$display("test erase and lock finished");
		summarize();
	end
endmodule : test_flash_self_program_controller
